/* File: src/ppb_top.sv */
// Register access over APB was decided locally.
`timescale 1ns/1ps
// parallel port bank: eight ports behind an apb slave
module ppb_top
  import ppb_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic clk,
  input wire logic resetn,
  input ppb_pkg::ppb_apb_req_type apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ppb_pkg::CONV_SEL_W-1:0] converter_channel_select,
  input ppb_pkg::ppb_pins_type pin_i,
  output ppb_pkg::ppb_pins_type pin_o,
  output ppb_pkg::ppb_pins_type pin_oe
);
  import ppb_pkg::*;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_WIDTH < MIN_ADDR_W || ADDR_WIDTH > 31) begin : g_bad_aw
    $error("address width cannot hold the register map");
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  // asserts at once, releases after two edges
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  ppb_pins_type pin_sync;
  ppb_pins_type latch_all;
  ppb_pins_type dir_all;
  ppb_pins_type rd_all;
  ppb_pins_type cell_o;
  ppb_pins_type cell_oe;
  ppb_pins_type conv_map;

  ppb_sync #(
    .WIDTH(NUM_PORTS * PORT_WIDTH)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n_r),
    .d(pin_i),
    .q(pin_sync)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic setup;
  logic access;
  logic mapped;
  logic [REG_IDX_W-1:0] idx;
  logic wr_go;
  logic clk_en;
  logic [31:0] rd_word;

  assign setup = apb_req.psel & ~apb_req.penable;
  // the write lands on the edge that completes the access phase
  assign access = apb_req.psel & apb_req.penable & pready;
  // anything above the sixteen words is unmapped
  assign mapped = (apb_req.paddr[ADDR_WIDTH-1:MIN_ADDR_W] == '0)
                  && (apb_req.paddr[31:ADDR_WIDTH] == '0);
  assign idx = apb_req.paddr[MIN_ADDR_W-1:2];
  assign wr_go = access & apb_req.pwrite & apb_req.pstrb[0] & mapped;
  assign clk_en = dir_all[CLK_PORT][CLK_EN_BIT];

  // ----------------------------------------------------------------
  // converter channel select to port b pins
  // ----------------------------------------------------------------
  always_comb begin
    conv_map = '0;
    for (int b = 0; b < PORT_WIDTH; b++) begin
      // codes above seven pick channels on other pins
      conv_map[CONV_PORT][b] = (converter_channel_select == CONV_SEL_W'(b));
    end
  end

  // ----------------------------------------------------------------
  // port cells
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    ppb_port_cell #(
      .IMPL(IMPL_MASK[p]),
      .DIRW(DIR_MASK[p])
    ) u_cell (
      .clk(clk),
      .rst_n(rst_n_r),
      .wr_latch(wr_go && (idx == LATCH_IDX[p])),
      .wr_dir(wr_go && (idx == DIR_IDX[p])),
      .wdata(apb_req.pwdata[7:0]),
      .conv_sel(conv_map[p]),
      .pin_in(pin_sync[p]),
      .latch_q(latch_all[p]),
      .dir_q(dir_all[p]),
      .rd_data(rd_all[p]),
      .pin_o(cell_o[p]),
      .pin_oe(cell_oe[p])
    );
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (idx == LATCH_IDX[p]) begin
        rd_word[7:0] = rd_all[p];
      end
      if (idx == DIR_IDX[p]) begin
        rd_word[7:0] = dir_all[p];
      end
    end
    // while the clock is out, the pin's data bit reads zero
    if (clk_en && idx == LATCH_IDX[CLK_PORT]) begin
      rd_word[CLK_PIN] = 1'b0;
    end
    if (!mapped) begin
      rd_word = '0;
    end
  end

  // ----------------------------------------------------------------
  // apb answer: no wait state, yet read data leaves a flop set in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
    end
  end

  // read data sampled in the setup cycle, zero for writes
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prdata <= '0;
    end else if (setup) begin
      prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_word;
    end
  end

  // ----------------------------------------------------------------
  // pin drive, with the system clock taking over port c pin two
  // ----------------------------------------------------------------
  // the clock passes through a mux, not a flop: a flop cannot carry it
  always_comb begin
    pin_o = cell_o;
    pin_oe = cell_oe;
    if (clk_en) begin
      pin_o[CLK_PORT][CLK_PIN] = clk;
      pin_oe[CLK_PORT][CLK_PIN] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [7:0] exp_a;
  assign exp_a = (dir_all[0] & latch_all[0]) | (~dir_all[0] & pin_sync[0]);

  chk_ready_follows: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    setup |=> pready ##1 !pready
  ) else $error("pready did not pulse after setup");

  chk_dir_write: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (wr_go && idx == IDX_PORT_A_DIRECTION)
      |=> dir_all[0] == $past(apb_req.pwdata[7:0]) ##1 pin_oe[0] == dir_all[0]
  ) else $error("port a direction write did not reach the pin enable");

  chk_latch_write: assert property (
    @(posedge clk)
    (rst_n_r && wr_go && idx == IDX_PORT_E_LATCH)
      |=> latch_all[4] == $past(apb_req.pwdata[7:0])
  ) else $error("latch write lost");

  chk_read_view: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (setup && !apb_req.pwrite && mapped && idx == IDX_PORT_A_LATCH)
      |=> prdata[7:0] == $past(exp_a)
  ) else $error("port a read did not follow direction");

  chk_reserved_zero: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    pready |-> prdata[31:8] == 24'h00_0000
      && !(idx == IDX_PORT_H_LATCH && $past(setup) && prdata[7:2] != 6'h00)
  ) else $error("reserved read bits not zero");

  chk_narrow_dir: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (dir_all[6][7:3] == 5'h00) && (dir_all[7][7:2] == 6'h00)
      && !dir_all[5][7] && !dir_all[2][6]
  ) else $error("absent direction bit set");

  chk_clock_pin: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    clk_en |-> pin_oe[CLK_PORT][CLK_PIN]
  ) else $error("clock output enable not driving the pin");

  chk_conv_float: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    $stable(converter_channel_select) && converter_channel_select < 5'h08
      |=> !pin_oe[CONV_PORT][$past(converter_channel_select[2:0])]
  ) else $error("converter channel drove its pin");

  chk_conv_zero: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (converter_channel_select == 5'h03 && !dir_all[CONV_PORT][3])
      |-> !rd_all[CONV_PORT][3]
  ) else $error("selected converter input read nonzero");

  chk_dir_reset: assert property (
    @(posedge clk)
    $rose(rst_n_r) |-> dir_all == '0 && pin_oe == '0
  ) else $error("directions not cleared by reset");

  // ----------------------------------------------------------------
  // bus answer checks
  // ----------------------------------------------------------------
  chk_err_ready: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    pslverr |-> pready
  ) else $error("pslverr raised outside the access phase");

  // an error answer only ever flags a hole in the map
  chk_err_decode: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    pready |-> pslverr == !mapped
  ) else $error("pslverr does not match the address decode");

  chk_ready_setup: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    pready |-> $past(setup)
  ) else $error("pready without a setup cycle before it");

  chk_ready_single: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    pready |=> !pready
  ) else $error("pready stood longer than one cycle");

  // read data stands from one setup to the next
  chk_data_stands: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    !setup |=> $stable(prdata)
  ) else $error("read data changed outside a setup cycle");

  chk_write_zero: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (setup && apb_req.pwrite) |=> prdata == 32'h0000_0000
  ) else $error("read data not zero during a write");

  chk_hole_zero: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (setup && !mapped) |=> prdata == 32'h0000_0000
  ) else $error("unmapped read returned data");

  // ----------------------------------------------------------------
  // register checks
  // ----------------------------------------------------------------
  // only a decoded write may move a direction register
  chk_dir_only_write: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    !wr_go |=> $stable(dir_all)
  ) else $error("direction register moved without a write");

  chk_hole_write: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (access && !mapped) |=> $stable(dir_all)
  ) else $error("unmapped write changed a direction register");

  // ----------------------------------------------------------------
  // clock pin and converter checks
  // ----------------------------------------------------------------
  chk_clock_read: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (setup && !apb_req.pwrite && clk_en && idx == IDX_PORT_C_LATCH)
      |=> !prdata[CLK_PIN]
  ) else $error("port c pin two read nonzero while the clock is out");

  chk_clock_idle: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    !clk_en |-> pin_oe[CLK_PORT][CLK_PIN] == cell_oe[CLK_PORT][CLK_PIN]
  ) else $error("clock pin override active while disabled");

  // codes above seven belong to channels on other ports
  chk_conv_onehot: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (converter_channel_select < 5'h08) |-> $onehot(conv_map[CONV_PORT])
  ) else $error("converter select did not claim exactly one port b pin");

  chk_conv_none: assert property (
    @(posedge clk) disable iff (!rst_n_r)
    (converter_channel_select > 5'h07) |-> conv_map == '0
  ) else $error("converter select beyond port b claimed a pin");

  // ----------------------------------------------------------------
  // internal reset and per-port checks
  // ----------------------------------------------------------------
  chk_reset_order: assert property (
    @(posedge clk)
    !rst_meta_r |=> !rst_n_r
  ) else $error("internal reset released ahead of its first stage");

  // masks and drive, one set of checks for each port
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_chk_port
    chk_dir_masked: assert property (
      @(posedge clk) disable iff (!rst_n_r)
      (dir_all[p] & ~DIR_MASK[p]) == 8'h00
    ) else $error("direction bit set outside the writable mask");

    chk_read_masked: assert property (
      @(posedge clk) disable iff (!rst_n_r)
      (rd_all[p] & ~IMPL_MASK[p]) == 8'h00
    ) else $error("absent data bit read as one");

    chk_oe_masked: assert property (
      @(posedge clk) disable iff (!rst_n_r)
      (pin_oe[p] & ~IMPL_MASK[p]) == 8'h00
    ) else $error("absent pin driven");

    chk_undriven_low: assert property (
      @(posedge clk) disable iff (!rst_n_r)
      (pin_o[p] & ~pin_oe[p]) == 8'h00
    ) else $error("undriven pin shows a nonzero output value");

    chk_drive_follows: assert property (
      @(posedge clk) disable iff (!rst_n_r)
      cell_oe[p] == $past(dir_all[p] & IMPL_MASK[p] & ~conv_map[p])
    ) else $error("pin enable does not follow direction and converter use");
  end

endmodule // ppb_top

/* File: src/ppb_pkg.sv */
// Notes on behaviour
// - fifty two-way pins across eight ports
// - ports A-D data, then direction registers
// - ports E-H data, E-H direction registers
// - absent data bits of C,F,G,H read zero
// - absent direction bits of F,G,H read zero
// - port C direction bit 7 is clock enable
// - clock enable drives system clock on C2
// - port A eight read/write latch bits
// - reset leaves port A latches untouched
// - direction one drives latch, zero floats pin
// - reset clears port A directions to input
// - output bits read back the latch
// - input bits read the pin level
// - latch writes always land, input unaffected
// - port B latches kept, directions per bit
// - converter select picks port B channel
// - selected input channel reads zero
// - selected channel never drives, direction steers read
package ppb_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 8;
  localparam int PORT_WIDTH = 8;
  localparam int REG_IDX_W = 4;
  localparam int CONV_SEL_W = 5;
  localparam int MIN_ADDR_W = 6;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [REG_IDX_W-1:0] IDX_PORT_A_LATCH = 4'h0;
  localparam logic [REG_IDX_W-1:0] IDX_PORT_B_LATCH = 4'h1;
  localparam logic [REG_IDX_W-1:0] IDX_PORT_C_LATCH = 4'h2;
  localparam logic [REG_IDX_W-1:0] IDX_PORT_D_LATCH = 4'h3;
  localparam logic [REG_IDX_W-1:0] IDX_PORT_A_DIRECTION = 4'h4;
  localparam logic [REG_IDX_W-1:0] IDX_PORT_B_DIRECTION = 4'h5;
  localparam logic [REG_IDX_W-1:0] IDX_PORT_C_DIRECTION = 4'h6;
  localparam logic [REG_IDX_W-1:0] IDX_PORT_D_DIRECTION = 4'h7;
  localparam logic [REG_IDX_W-1:0] IDX_PORT_E_LATCH = 4'h8;
  localparam logic [REG_IDX_W-1:0] IDX_PORT_F_LATCH = 4'h9;
  localparam logic [REG_IDX_W-1:0] IDX_PORT_G_LATCH = 4'ha;
  localparam logic [REG_IDX_W-1:0] IDX_PORT_H_LATCH = 4'hb;
  localparam logic [REG_IDX_W-1:0] IDX_PORT_E_DIRECTION = 4'hc;
  localparam logic [REG_IDX_W-1:0] IDX_PORT_F_DIRECTION = 4'hd;
  localparam logic [REG_IDX_W-1:0] IDX_PORT_G_DIRECTION = 4'he;
  localparam logic [REG_IDX_W-1:0] IDX_PORT_H_DIRECTION = 4'hf;

  // per-port tables, entry 0 is port A
  localparam logic [NUM_PORTS-1:0][REG_IDX_W-1:0] LATCH_IDX = {
    IDX_PORT_H_LATCH, IDX_PORT_G_LATCH, IDX_PORT_F_LATCH, IDX_PORT_E_LATCH,
    IDX_PORT_D_LATCH, IDX_PORT_C_LATCH, IDX_PORT_B_LATCH, IDX_PORT_A_LATCH};
  localparam logic [NUM_PORTS-1:0][REG_IDX_W-1:0] DIR_IDX = {
    IDX_PORT_H_DIRECTION, IDX_PORT_G_DIRECTION, IDX_PORT_F_DIRECTION,
    IDX_PORT_E_DIRECTION, IDX_PORT_D_DIRECTION, IDX_PORT_C_DIRECTION,
    IDX_PORT_B_DIRECTION, IDX_PORT_A_DIRECTION};

  // ----------------------------------------------------------------
  // implemented pins and writable direction bits
  // ----------------------------------------------------------------
  localparam logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] IMPL_MASK = {
    8'h03, 8'h07, 8'h7f, 8'hff, 8'hff, 8'h3f, 8'hff, 8'hff};
  localparam logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] DIR_MASK = {
    8'h03, 8'h07, 8'h7f, 8'hff, 8'hff, 8'hbf, 8'hff, 8'hff};
  localparam logic [PORT_WIDTH-1:0] DIR_RESET = 8'h00;

  // special pins
  localparam int CONV_PORT = 1;
  localparam int CLK_PORT = 2;
  localparam int CLK_PIN = 2;
  localparam int CLK_EN_BIT = 7;

  // ----------------------------------------------------------------
  // bus carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } ppb_apb_req_type;

  typedef logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] ppb_pins_type;

endpackage

/* File: src/ppb_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser for asynchronous pin levels
module ppb_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // first stage is read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule // ppb_sync

/* File: src/ppb_port_cell.sv */
`timescale 1ns/1ps
// one eight-pin port: latch, direction, pin drive and read view
module ppb_port_cell
  import ppb_pkg::*;
#(
  parameter logic [7:0] IMPL = 8'hff,
  parameter logic [7:0] DIRW = 8'hff
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_latch,
  input wire logic wr_dir,
  input wire logic [7:0] wdata,
  input wire logic [7:0] conv_sel,
  input wire logic [7:0] pin_in,
  output logic [7:0] latch_q,
  output logic [7:0] dir_q,
  output logic [7:0] rd_data,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe
);

  logic [7:0] drive;

  // latch has no reset: contents survive a system reset
  always_ff @(posedge clk) begin
    if (wr_latch) begin
      latch_q <= wdata & IMPL;
    end
  end

  // direction bits, cleared by reset to input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= DIR_RESET;
    end else if (wr_dir) begin
      dir_q <= wdata & DIRW;
    end
  end

  // converter channels never drive, whatever the direction says
  assign drive = dir_q & IMPL & ~conv_sel;

  // pin drive registered; data masked by enable so no unknown leaves
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe <= '0;
      pin_o <= '0;
    end else begin
      pin_oe <= drive;
      pin_o <= latch_q & drive;
    end
  end

  // output bits show the latch, inputs the pin, converter inputs zero
  assign rd_data = IMPL & ((dir_q & latch_q) | (~dir_q & ~conv_sel & pin_in));

endmodule // ppb_port_cell

/* File: sim/ppb_pin_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// board side of the pins
// ------------------------------------------------------------
module ppb_pin_model
  import ppb_pkg::*;
(
  input ppb_pkg::ppb_pins_type pin_o,
  input ppb_pkg::ppb_pins_type pin_oe,
  input ppb_pkg::ppb_pins_type board_level,
  output ppb_pkg::ppb_pins_type pin_i
);
  // a driven pin shows the chip's value, a floating one the board's level;
  // the board never fights the chip, so contention is not modelled
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      pin_i[p] = (pin_o[p] & pin_oe[p]) | (board_level[p] & ~pin_oe[p]);
    end
  end
endmodule // ppb_pin_model

/* File: sim/ppb_top_tb_top.sv */
`timescale 1ns/1ps
module ppb_top_tb_top;
  import ppb_pkg::*;
  logic clk;
  logic resetn;
  ppb_apb_req_type apb_req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [CONV_SEL_W-1:0] converter_channel_select;
  ppb_pins_type pin_i;
  ppb_pins_type pin_o;
  ppb_pins_type pin_oe;
  ppb_pins_type board;
  int miscompares;
  int compares;
  logic [31:0] rv;
  logic ev;
  logic [7:0] wv;

  ppb_top u_ppb_top (.clk(clk), .resetn(resetn), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .converter_channel_select(converter_channel_select),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));
  ppb_pin_model u_ppb_pin_model (.pin_o(pin_o), .pin_oe(pin_oe), .board_level(board),
    .pin_i(pin_i));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one transfer; the request stands until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [31:0] a, input logic [7:0] d);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                 pwdata: {24'h0, d}, pstrb: 4'hf};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    // idle edge so a following call never re-drives psel in this time step
    @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    apb(1'b1, {26'h0, idx, 2'b00}, d);
  endtask

  task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
    apb(1'b0, {26'h0, idx, 2'b00}, 8'h00);
    chk(rv, {24'h0, exp});
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic results();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // clock, watchdog, tests
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // whole run is well under a thousand cycles
  initial begin
    #200000;
    miscompares++;
    results();
  end

  initial begin
    // start high, then fall, so the reset flops see a real falling edge
    resetn = 1'b1;
    apb_req = '0;
    converter_channel_select = 5'h08;
    board = '0;
    miscompares = 0;
    compares = 0;
    #1 resetn = 1'b0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    for (int p = 0; p < NUM_PORTS; p++) begin
      rd(DIR_IDX[p], DIR_RESET);
      chk(pin_oe[p], 8'h00);
    end
    done("reset");
    // all ones everywhere; clock enable kept off so port C stays plain
    for (int p = 0; p < NUM_PORTS; p++) begin
      wv = (p == CLK_PORT) ? 8'h7f : 8'hff;
      wr(LATCH_IDX[p], 8'hff);
      wr(DIR_IDX[p], wv);
      rd(DIR_IDX[p], DIR_MASK[p] & wv);
      rd(LATCH_IDX[p], IMPL_MASK[p]);
    end
    @(negedge clk);
    for (int p = 0; p < NUM_PORTS; p++) begin
      chk(pin_oe[p], IMPL_MASK[p]);
      chk(pin_o[p], IMPL_MASK[p]);
    end
    @(posedge clk);
    done("reserved");
    for (int p = 0; p < NUM_PORTS; p++) wr(DIR_IDX[p], 8'h00);
    board[0] <= 8'ha5;
    wr(IDX_PORT_A_LATCH, 8'h3c);
    repeat (3) @(posedge clk);
    rd(IDX_PORT_A_LATCH, 8'ha5);
    wr(IDX_PORT_A_DIRECTION, 8'h0f);
    repeat (3) @(posedge clk);
    rd(IDX_PORT_A_LATCH, 8'hac);
    @(negedge clk);
    chk(pin_oe[0], 8'h0f);
    chk(pin_o[0], 8'h0c);
    @(posedge clk);
    done("direction");
    board[1] <= 8'hff;
    wr(IDX_PORT_B_LATCH, 8'h08);
    for (int c = 0; c < 8; c++) begin
      converter_channel_select <= 5'(c);
      repeat (3) @(posedge clk);
      rd(IDX_PORT_B_LATCH, ~(8'h01 << c));
    end
    converter_channel_select <= 5'h03;
    wr(IDX_PORT_B_DIRECTION, 8'h08);
    rd(IDX_PORT_B_LATCH, 8'hff);
    chk(pin_oe[1], 8'h00);
    converter_channel_select <= 5'h08;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(pin_oe[1], 8'h08);
    @(posedge clk);
    done("converter");
    board[2] <= 8'h3f;
    wr(IDX_PORT_C_LATCH, 8'h00);
    wr(IDX_PORT_C_DIRECTION, 8'h80);
    rd(IDX_PORT_C_DIRECTION, 8'h80);
    repeat (2) @(posedge clk);
    rd(IDX_PORT_C_LATCH, 8'h3b);
    #1 chk(pin_o[2][2], 1'b1);
    @(negedge clk);
    chk(pin_o[2][2], 1'b0);
    chk(pin_oe[2], 8'h04);
    @(posedge clk);
    done("clock_out");
    apb(1'b1, 32'h40, 8'hff);
    chk(ev, 1'b1);
    apb(1'b1, 32'h50, 8'hff);
    chk(ev, 1'b1);
    rd(IDX_PORT_A_DIRECTION, 8'h0f);
    chk(ev, 1'b0);
    apb(1'b0, 32'h40, 8'h00);
    chk(rv, 32'h0);
    chk(ev, 1'b1);
    done("unmapped");
    resetn <= 1'b0;
    @(negedge clk);
    chk(pin_oe[0], 8'h00);
    chk(pin_oe[2][2], 1'b0);
    @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(IDX_PORT_C_DIRECTION, 8'h00);
    wr(IDX_PORT_A_DIRECTION, 8'hff);
    rd(IDX_PORT_A_LATCH, 8'h3c);
    done("second_reset");
    results();
  end
endmodule // ppb_top_tb_top
